// File: tsreg_pkg.sv
// Shared constants of the temperature sensor register map
package tsreg_pkg;
  // Register pointer values
  localparam logic [3:0] PTR_CAPABILITY = 4'h0;
  localparam logic [3:0] PTR_CONFIG     = 4'h1;
  localparam logic [3:0] PTR_HIGH_LIM   = 4'h2;
  localparam logic [3:0] PTR_LOW_LIM    = 4'h3;
  localparam logic [3:0] PTR_CRIT_LIM   = 4'h4;
  localparam logic [3:0] PTR_AMBIENT    = 4'h5;
  localparam logic [3:0] PTR_MAKER_ID   = 4'h6;
  localparam logic [3:0] PTR_PART_ID    = 4'h7;
  localparam logic [3:0] PTR_RESOLUTION = 4'h8;

  // Configuration field positions
  localparam int CFG_HYST_HI   = 10;
  localparam int CFG_HYST_LO   = 9;
  localparam int CFG_STOP      = 8;
  localparam int CFG_CRIT_LOCK = 7;
  localparam int CFG_WIN_LOCK  = 6;
  localparam int CFG_INT_CLR   = 5;
  localparam int CFG_STAT      = 4;
  localparam int CFG_OUT_EN    = 3;
  localparam int CFG_SRC_SEL   = 2;
  localparam int CFG_POL       = 1;
  localparam int CFG_MODE      = 0;

  // Temperature word layout
  localparam int TEMP_MSB      = 12;
  localparam int TEMP_LSB      = 2;
  localparam int TEMP_W        = 11;
  localparam int FLAG_CRIT     = 15;
  localparam int FLAG_HIGH     = 14;
  localparam int FLAG_LOW      = 13;

  // Hysteresis steps in quarter degrees: 0, 1.5, 3.0, 6.0
  localparam logic [TEMP_W-1:0] HYST_Q0 = 11'h000;
  localparam logic [TEMP_W-1:0] HYST_Q1 = 11'h006;
  localparam logic [TEMP_W-1:0] HYST_Q2 = 11'h00c;
  localparam logic [TEMP_W-1:0] HYST_Q3 = 11'h018;

  // Fixed read values and reset values
  localparam logic [15:0] CAPABILITY_VAL = 16'h001f;
  localparam logic [15:0] CONFIG_RST     = 16'h0000;
  localparam logic [TEMP_W-1:0] LIMIT_RST = 11'h000;
  localparam logic [7:0]  RESOLUTION_RST = 8'h03;
  localparam logic [15:0] UNMAPPED_VAL   = 16'h0000;
endpackage

// File: tsreg_top.sv
// Register file, limit comparison and alert control of the temperature sensor
`timescale 1ns/1ps

// Function
// [RULE1] Pointer 0x00..0x08 selects nine registers
// [RULE2] Limits: sign bit 12, magnitude 11..2
// [RULE3] Ambient flags bits 15..13: crit, high, low
// [RULE4] Configuration sixteen bits, upper five zero
// [RULE5] Bits 10..9 set window comparison hysteresis
// [RULE6] Bit 8 selects continuous or low power stop
// [RULE7] Stopped: ambient keeps last conversion
// [RULE8] Bits 7,6 lock critical and window limits
// [RULE9] Locks clear only at power-on reset
// [RULE10] Bits 5..0 control the alert pin
// [RULE11] Alert source: all limits or critical only
// [RULE12] Hysteresis codes 0, 1.5, 3.0, 6.0 degrees
// [RULE13] Hysteresis frozen while any lock set
// [RULE14] Locked: cannot enter stop, may leave it
// [RULE15] Writes to read-only bits change nothing
module tsreg_top #(
  parameter logic [15:0] MAKER_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] PART_ID  = 16'h5678  // Arbitrary value
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [3:0]  ptr_i,
  input  wire logic        wr_en_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        rd_en_i,
  output logic      [15:0] rd_data_o,
  input  wire logic        conv_valid_i,
  input  wire logic [15:0] conv_data_i,
  output logic             conv_run_o,
  output logic             alert_o,
  output logic             alert_oe_b_o
);

  // Extract the signed quarter-degree field of a temperature word
  function automatic logic signed [10:0] temp_field(input logic [15:0] w);
    temp_field = w[tsreg_pkg::TEMP_MSB:tsreg_pkg::TEMP_LSB];
  endfunction

  // Pack a signed field back into a register word, unused bits zero
  function automatic logic [15:0] temp_word(input logic [10:0] f);
    temp_word = {3'h0, f, 2'h0};
  endfunction

  // Helpers above hard-wire an eleven-bit field; refuse any other field width
  if (tsreg_pkg::TEMP_MSB - tsreg_pkg::TEMP_LSB + 1 != tsreg_pkg::TEMP_W
      || tsreg_pkg::TEMP_W != 11)
  begin
    $error("temperature field layout not supported");
  end

  // Stored configuration, limits, flags and read word
  logic [1:0]  hyst_q;
  logic        stop_q;
  logic        crit_lock_q;
  logic        win_lock_q;
  logic        out_en_q;
  logic        src_sel_q;
  logic        pol_q;
  logic        mode_q;
  logic [10:0] high_lim_q;
  logic [10:0] low_lim_q;
  logic [10:0] crit_lim_q;
  logic [10:0] ambient_q;
  logic [7:0]  resolution_q;
  logic        high_flag_q;
  logic        low_flag_q;
  logic        event_prev_q;
  logic        int_latch_q;
  logic [15:0] rd_data_q;

  // Decode and comparison nets
  logic        any_lock;
  logic        cfg_wr;
  logic        int_clr;
  logic [10:0] hyst_amt;
  logic signed [11:0] amb_s;
  logic signed [11:0] high_s;
  logic signed [11:0] low_s;
  logic signed [11:0] hyst_s;
  logic        crit_flag;
  logic        alert_event;
  logic        alert_active;
  logic [15:0] cfg_word;
  logic [15:0] ambient_word;

  // Configuration write decode and the interrupt clear strobe
  assign any_lock = crit_lock_q | win_lock_q;
  assign cfg_wr   = wr_en_i && (ptr_i == tsreg_pkg::PTR_CONFIG);
  assign int_clr  = cfg_wr && wr_data_i[tsreg_pkg::CFG_INT_CLR];

  // Hysteresis code to quarter-degree amount
  always_comb
  begin
    case (hyst_q)
      2'h0:    hyst_amt = tsreg_pkg::HYST_Q0; // [RULE12]
      2'h1:    hyst_amt = tsreg_pkg::HYST_Q1; // [RULE12]
      2'h2:    hyst_amt = tsreg_pkg::HYST_Q2; // [RULE12]
      default: hyst_amt = tsreg_pkg::HYST_Q3; // [RULE12]
    endcase
  end

  // One extra bit so limit minus hysteresis cannot wrap
  assign amb_s  = {ambient_q[10], ambient_q};
  assign high_s = {high_lim_q[10], high_lim_q};
  assign low_s  = {low_lim_q[10], low_lim_q};
  assign hyst_s = {1'b0, hyst_amt};
  assign crit_flag = $signed(ambient_q) >= $signed(crit_lim_q); // [RULE3]

  // Hysteresis field; frozen under either lock so a locked band cannot narrow
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      hyst_q <= tsreg_pkg::CONFIG_RST[tsreg_pkg::CFG_HYST_HI:tsreg_pkg::CFG_HYST_LO];
    else if (cfg_wr && !any_lock)
      hyst_q <= wr_data_i[tsreg_pkg::CFG_HYST_HI:tsreg_pkg::CFG_HYST_LO]; // [RULE5] [RULE13]
  end

  // Shutdown bit; a locked part may leave shutdown but never enter it
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      stop_q <= tsreg_pkg::CONFIG_RST[tsreg_pkg::CFG_STOP];
    else if (cfg_wr)
    begin
      if (any_lock)
        stop_q <= stop_q & wr_data_i[tsreg_pkg::CFG_STOP]; // [RULE14]
      else
        stop_q <= wr_data_i[tsreg_pkg::CFG_STOP]; // [RULE6]
    end
  end

  // Lock bits are sticky; writing zero does nothing, only reset frees them
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      crit_lock_q <= tsreg_pkg::CONFIG_RST[tsreg_pkg::CFG_CRIT_LOCK];
      win_lock_q  <= tsreg_pkg::CONFIG_RST[tsreg_pkg::CFG_WIN_LOCK];
    end
    else if (cfg_wr)
    begin
      crit_lock_q <= crit_lock_q | wr_data_i[tsreg_pkg::CFG_CRIT_LOCK]; // [RULE8] [RULE9]
      win_lock_q  <= win_lock_q | wr_data_i[tsreg_pkg::CFG_WIN_LOCK]; // [RULE8] [RULE9]
    end
  end

  // Alert pin controls; deliberately left writable under the locks
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      out_en_q  <= tsreg_pkg::CONFIG_RST[tsreg_pkg::CFG_OUT_EN];
      src_sel_q <= tsreg_pkg::CONFIG_RST[tsreg_pkg::CFG_SRC_SEL];
      pol_q     <= tsreg_pkg::CONFIG_RST[tsreg_pkg::CFG_POL];
      mode_q    <= tsreg_pkg::CONFIG_RST[tsreg_pkg::CFG_MODE];
    end
    else if (cfg_wr)
    begin
      out_en_q  <= wr_data_i[tsreg_pkg::CFG_OUT_EN]; // [RULE10]
      src_sel_q <= wr_data_i[tsreg_pkg::CFG_SRC_SEL]; // [RULE10] [RULE11]
      pol_q     <= wr_data_i[tsreg_pkg::CFG_POL]; // [RULE10]
      mode_q    <= wr_data_i[tsreg_pkg::CFG_MODE]; // [RULE10]
    end
  end

  // Upper window limit, guarded by the window lock
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      high_lim_q <= tsreg_pkg::LIMIT_RST;
    else if (wr_en_i && ptr_i == tsreg_pkg::PTR_HIGH_LIM && !win_lock_q)
      high_lim_q <= temp_field(wr_data_i); // [RULE2] [RULE8]
  end

  // Lower window limit, same lock as the upper one
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      low_lim_q <= tsreg_pkg::LIMIT_RST;
    else if (wr_en_i && ptr_i == tsreg_pkg::PTR_LOW_LIM && !win_lock_q)
      low_lim_q <= temp_field(wr_data_i); // [RULE2] [RULE8]
  end

  // Critical limit has a lock of its own
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      crit_lim_q <= tsreg_pkg::LIMIT_RST;
    else if (wr_en_i && ptr_i == tsreg_pkg::PTR_CRIT_LIM && !crit_lock_q)
      crit_lim_q <= temp_field(wr_data_i); // [RULE2] [RULE8]
  end

  // Resolution is the only other writable register
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      resolution_q <= tsreg_pkg::RESOLUTION_RST;
    else if (wr_en_i && ptr_i == tsreg_pkg::PTR_RESOLUTION)
      resolution_q <= wr_data_i[7:0];
  end

  // Ambient capture; results arriving while stopped are dropped
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      ambient_q <= tsreg_pkg::LIMIT_RST;
    else if (conv_valid_i && !stop_q)
      ambient_q <= temp_field(conv_data_i); // [RULE7]
  end

  // Conversions run unless stopped
  assign conv_run_o = ~stop_q; // [RULE6] [RULE7]

  // Upper window flag with hysteresis so a slow drift does not chatter
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      high_flag_q <= 1'b0;
    else if (amb_s > high_s)
      high_flag_q <= 1'b1; // [RULE3]
    else if (amb_s <= high_s - hyst_s)
      high_flag_q <= 1'b0; // [RULE5]
  end

  // Lower window flag, band mirrored above the lower limit
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      low_flag_q <= 1'b0;
    else if (amb_s < low_s)
      low_flag_q <= 1'b1; // [RULE3]
    else if (amb_s >= low_s + hyst_s)
      low_flag_q <= 1'b0; // [RULE5]
  end

  // Alert source: all three limits or the critical limit alone
  assign alert_event = src_sel_q ? crit_flag
                                 : (crit_flag | high_flag_q | low_flag_q); // [RULE11]

  // Previous event level for the rising-edge detect
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      event_prev_q <= 1'b0;
    else
      event_prev_q <= alert_event;
  end

  // Interrupt latch; a new event in the same cycle as a clear wins
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      int_latch_q <= 1'b0;
    else if (alert_event && !event_prev_q)
      int_latch_q <= 1'b1; // [RULE10]
    else if (int_clr)
      int_latch_q <= 1'b0; // [RULE10]
  end

  // Comparator mode follows the event; interrupt mode holds until cleared
  assign alert_active = mode_q ? int_latch_q : alert_event; // [RULE10]
  assign alert_o      = pol_q ? alert_active : ~alert_active; // [RULE10]
  assign alert_oe_b_o = ~out_en_q; // [RULE10]

  // Read words; the clear bit always reads zero
  assign cfg_word = {5'h00, hyst_q, stop_q, crit_lock_q, win_lock_q, 1'b0,
                     alert_active, out_en_q, src_sel_q, pol_q, mode_q}; // [RULE4]
  assign ambient_word = {crit_flag, high_flag_q, low_flag_q, 13'h0000}
                        | temp_word(ambient_q); // [RULE3]

  // Registered read mux; read-only pointers ignore writes entirely
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      rd_data_q <= tsreg_pkg::UNMAPPED_VAL;
    else if (rd_en_i)
    begin
      case (ptr_i)
        tsreg_pkg::PTR_CAPABILITY: rd_data_q <= tsreg_pkg::CAPABILITY_VAL; // [RULE1] [RULE15]
        tsreg_pkg::PTR_CONFIG:     rd_data_q <= cfg_word; // [RULE1]
        tsreg_pkg::PTR_HIGH_LIM:   rd_data_q <= temp_word(high_lim_q); // [RULE1] [RULE2]
        tsreg_pkg::PTR_LOW_LIM:    rd_data_q <= temp_word(low_lim_q); // [RULE1] [RULE2]
        tsreg_pkg::PTR_CRIT_LIM:   rd_data_q <= temp_word(crit_lim_q); // [RULE1] [RULE2]
        tsreg_pkg::PTR_AMBIENT:    rd_data_q <= ambient_word; // [RULE1] [RULE15]
        tsreg_pkg::PTR_MAKER_ID:   rd_data_q <= MAKER_ID; // [RULE1] [RULE15]
        tsreg_pkg::PTR_PART_ID:    rd_data_q <= PART_ID; // [RULE1] [RULE15]
        tsreg_pkg::PTR_RESOLUTION: rd_data_q <= {8'h00, resolution_q}; // [RULE1]
        default:                   rd_data_q <= tsreg_pkg::UNMAPPED_VAL;
      endcase
    end
  end

  // Read data straight from its flip-flops
  assign rd_data_o = rd_data_q;

endmodule

// File: tsreg_properties.sv
// Port assertions for the temperature sensor register map
`timescale 1ns/1ps
module tsreg_properties (
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic [3:0]  ptr_i,
  input wire logic        wr_en_i,
  input wire logic [15:0] wr_data_i,
  input wire logic        rd_en_i,
  input wire logic [15:0] rd_data_o,
  input wire logic        conv_valid_i,
  input wire logic        conv_run_o,
  input wire logic        alert_o,
  input wire logic        alert_oe_b_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Config write and its pin enable request
  wire logic cfg_wr = wr_en_i && ptr_i == 4'h1;
  wire logic oe_req = wr_data_i[3];
  // Read word lands one cycle after the strobe, then stands
  a_cap_word: assert property (rd_en_i && ptr_i == 4'h0 |=> rd_data_o == 16'h001f)
    else $error("capability word wrong");
  a_unmapped_zero: assert property (rd_en_i && ptr_i > 4'h8 |=> rd_data_o == 16'h0000)
    else $error("unmapped read not zero");
  a_read_stands: assert property (!rd_en_i |=> $stable(rd_data_o))
    else $error("read word moved");
  a_limit_pad: assert property (rd_en_i && ptr_i inside {4'h2, 4'h3, 4'h4}
    |=> rd_data_o[15:13] == 3'h0 && rd_data_o[1:0] == 2'h0) else $error("limit pad bits");
  a_cfg_pad: assert property (rd_en_i && ptr_i == 4'h1 |=> rd_data_o[15:11] == 5'h00)
    else $error("config upper bits");
  a_oe_follow: assert property (cfg_wr |=> alert_oe_b_o == !$past(oe_req))
    else $error("pin enable wrong");
  a_run_resume: assert property (cfg_wr && !wr_data_i[8] |=> conv_run_o)
    else $error("stop not cleared");
  a_run_steady: assert property (!cfg_wr |=> $stable(conv_run_o))
    else $error("run state moved");
  // Main scenarios reached
  c_stop: cover property (cfg_wr ##1 !conv_run_o);
  c_conv_read: cover property (conv_valid_i ##[1:8] (rd_en_i && ptr_i == 4'h5));
  c_alert: cover property (!alert_oe_b_o && alert_o);
endmodule

// File: tsreg_host.sv
// Host model issuing register and conversion traffic at falling edges
`timescale 1ns/1ps
module tsreg_host (
  input  wire logic        core_clk_i,
  input  wire logic [15:0] rd_data_o,
  output logic      [3:0]  ptr_i,
  output logic             wr_en_i,
  output logic      [15:0] wr_data_i,
  output logic             rd_en_i,
  output logic             conv_valid_i,
  output logic      [15:0] conv_data_i
);
  // Idle bus; released lines get inverted so stale data never looks valid
  initial {ptr_i, wr_en_i, wr_data_i, rd_en_i, conv_valid_i, conv_data_i} = '0;
  task automatic wr(input logic [3:0] p, input logic [15:0] d);
    @(negedge core_clk_i);
    {ptr_i, wr_data_i, wr_en_i} = {p, d, 1'b1};
    @(negedge core_clk_i);
    {ptr_i, wr_data_i, wr_en_i} = {~p, ~d, 1'b0};
  endtask
  task automatic rd(input logic [3:0] p, output logic [15:0] d);
    @(negedge core_clk_i);
    {ptr_i, rd_en_i} = {p, 1'b1};
    @(negedge core_clk_i);
    {ptr_i, rd_en_i} = {~p, 1'b0};
    d = rd_data_o;
  endtask
  // High and low flags trail the ambient word by a cycle, so wait before returning
  task automatic conv(input logic [15:0] d);
    @(negedge core_clk_i);
    {conv_data_i, conv_valid_i} = {d, 1'b1};
    @(negedge core_clk_i);
    {conv_data_i, conv_valid_i} = {~d, 1'b0};
    repeat (2) @(negedge core_clk_i);
  endtask
endmodule

// File: tsreg_top_tb.sv
// Self-checking bench for the temperature sensor register map
`timescale 1ns/1ps
module tsreg_top_tb;
  logic        core_clk_i, rst_b_i, wr_en_i, rd_en_i, conv_valid_i;
  logic        conv_run_o, alert_o, alert_oe_b_o;
  logic [3:0]  ptr_i;
  logic [15:0] wr_data_i, rd_data_o, conv_data_i, v;
  int          errors = 0;
  int          n_checks = 0;
  tsreg_top uut (.core_clk_i, .rst_b_i, .ptr_i, .wr_en_i, .wr_data_i, .rd_en_i, .rd_data_o,
    .conv_valid_i, .conv_data_i, .conv_run_o, .alert_o, .alert_oe_b_o);
  tsreg_host host (.core_clk_i, .rd_data_o, .ptr_i, .wr_en_i, .wr_data_i, .rd_en_i,
    .conv_valid_i, .conv_data_i);
  // Clock and compare helpers
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [3:0] p, input logic [15:0] e);
    host.rd(p, v);
    chk(v, e);
  endtask
  task automatic do_reset;
    rst_b_i = 1'b0;
    repeat (20) @(negedge core_clk_i);
    rst_b_i = 1'b1;
  endtask
  task automatic complete_run;
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Whole map after reset, one unmapped pointer included
  task automatic t_map;
    logic [15:0] e [10] = '{16'h001f, 16'h0010, 16'h0000, 16'h0000, 16'h0000,
      16'h8000, 16'h1234, 16'h5678, 16'h0003, 16'h0000};
    for (int i = 0; i < 10; i++)
      rc(i[3:0], e[i]);
  endtask
  // Limit padding, all flags, writes to read-only places
  task automatic t_regs;
    host.wr(4'h2, 16'hffff);
    host.wr(4'h3, 16'h0ffc);
    host.conv(16'h0000);
    rc(4'h5, 16'he000);
    host.wr(4'h5, 16'h1234);
    host.wr(4'h0, 16'h1234);
    rc(4'h5, 16'he000);
    rc(4'h0, 16'h001f);
    rc(4'h2, 16'h1ffc);
    host.wr(4'h3, 16'h0000);
    host.wr(4'h4, 16'h0400);
    host.conv(16'h0000);
    rc(4'h5, 16'h4000);
  endtask
  // Pin polarity, enable and source with only the window event active
  task automatic t_alert;
    host.wr(4'h1, 16'h000a);
    chk({15'h0, alert_o}, 16'h0001);
    chk({15'h0, alert_oe_b_o}, 16'h0000);
    rc(4'h1, 16'h001a);
    host.wr(4'h1, 16'h000e);
    chk({15'h0, alert_o}, 16'h0000);
    host.wr(4'h1, 16'h000c);
    chk({15'h0, alert_o}, 16'h0001);
    host.wr(4'h1, 16'h0000);
    chk({15'h0, alert_oe_b_o}, 16'h0001);
  endtask
  // Each hysteresis code: set above, hold inside band, clear at band edge
  task automatic t_hyst;
    logic [15:0] h [4] = '{16'h0000, 16'h0018, 16'h0030, 16'h0060};
    host.wr(4'h2, 16'h0190);
    for (int k = 0; k < 4; k++)
    begin
      host.wr(4'h1, 16'(k) << 9);
      host.conv(16'h0194);
      host.conv(16'h0194 - h[k]);
      rc(4'h5, 16'h4194 - h[k]);
      host.conv(16'h0190 - h[k]);
      rc(4'h5, 16'h0190 - h[k]);
    end
  endtask
  // Stop freezes the ambient word; hysteresis still writable meanwhile
  task automatic t_stop;
    host.wr(4'h1, 16'h0100);
    chk({15'h0, conv_run_o}, 16'h0000);
    host.conv(16'h0250);
    rc(4'h5, 16'h0130);
    host.wr(4'h1, 16'h0300);
    rc(4'h1, 16'h0300);
    host.wr(4'h1, 16'h0000);
    chk({15'h0, conv_run_o}, 16'h0001);
  endtask
  // Interrupt mode holds past the event until cleared; resolution keeps low byte
  task automatic t_irq;
    host.wr(4'h1, 16'h0029);
    chk({15'h0, alert_o}, 16'h0001);
    rc(4'h1, 16'h0009);
    host.conv(16'h0200);
    chk({15'h0, alert_o}, 16'h0000);
    host.conv(16'h0130);
    chk({15'h0, alert_o}, 16'h0000);
    host.wr(4'h1, 16'h0029);
    chk({15'h0, alert_o}, 16'h0001);
    host.wr(4'h8, 16'hff02);
    rc(4'h8, 16'h0002);
  endtask
  // Locks refuse limit, hysteresis and stop entry changes until reset; leaving stop still works
  task automatic t_lock;
    host.wr(4'h1, 16'h01c0);
    host.wr(4'h2, 16'h0100);
    host.wr(4'h3, 16'h0100);
    host.wr(4'h4, 16'h0100);
    rc(4'h2, 16'h0190);
    rc(4'h3, 16'h0000);
    rc(4'h4, 16'h0400);
    host.wr(4'h1, 16'h0000);
    chk({15'h0, conv_run_o}, 16'h0001);
    host.wr(4'h1, 16'h0700);
    rc(4'h1, 16'h00c0);
    do_reset();
    rc(4'h1, 16'h0010);
  endtask
  initial
  begin
    do_reset();
    t_map();
    t_regs();
    t_alert();
    t_hyst();
    t_stop();
    t_irq();
    t_lock();
    complete_run();
  end
  // Watchdog well beyond the few hundred cycles the run needs
  initial
  begin
    #500000;
    errors++;
    complete_run();
  end
endmodule
bind tsreg_top tsreg_properties u_props (.core_clk_i, .rst_b_i, .ptr_i, .wr_en_i, .wr_data_i,
  .rd_en_i, .rd_data_o, .conv_valid_i, .conv_run_o, .alert_o, .alert_oe_b_o);
